// ===== common/cicr_pkg.sv
// Package with register map, field positions and carrier types of the converter control registers.
package cicr_pkg;

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [7:0] CICR_ADDR_IRQ_ENABLES = 8'h03;
   localparam logic [7:0] CICR_ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] CICR_ADDR_FULL_SCALE_LOW = 8'h06;
   localparam logic [7:0] CICR_ADDR_FULL_SCALE_HIGH_SLEEP = 8'h07;
   localparam logic [7:0] CICR_ADDR_OUTPUT_SWITCH_MODE = 8'h08;
   localparam logic [7:0] CICR_ADDR_CLOCK_PHASE_STATUS = 8'h0c;
   localparam logic [7:0] CICR_ADDR_SYNC_INPUT_PHASE_STATUS = 8'h0d;
   localparam logic [7:0] CICR_ADDR_RECEIVER_CONFIG = 8'h10;

   // ==========================================================================
   // Controllers and field positions
   // ==========================================================================
   // Controller index i owns status bit 2*i (locked) and 2*i+1 (lost).
   localparam int CICR_NUM_CTL = 3;
   localparam int CICR_CTL_RECEIVER = 0;
   localparam int CICR_CTL_PHASE_LOOP = 1;
   localparam int CICR_CTL_SYNC = 2;
   localparam int CICR_IRQ_W = 2 * CICR_NUM_CTL;

   localparam int CICR_FSC_W = 10;
   localparam int CICR_FSC_HIGH_W = 2;
   localparam int CICR_SLEEP_BIT = 7;
   localparam int CICR_MODE_W = 2;

   localparam int CICR_CLOCK_EARLY_BIT = 2;
   localparam int CICR_CLOCK_LATE_BIT = 0;
   localparam int CICR_SYNC_PH90_BIT = 5;
   localparam int CICR_SYNC_PH0_BIT = 4;

   localparam int CICR_SYNC_FLAG_CLEAR_BIT = 7;
   localparam int CICR_SYNC_AUTO_RETRACK_BIT = 6;
   localparam int CICR_SYNC_ROLE_BIT = 5;
   localparam int CICR_SYNC_ENABLE_BIT = 4;
   localparam int CICR_RCV_FLAG_CLEAR_BIT = 2;
   localparam int CICR_RCV_AUTO_RETRACK_BIT = 1;
   localparam int CICR_RCV_ENABLE_BIT = 0;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [CICR_IRQ_W-1:0] CICR_RST_IRQ_ENABLES = 6'h00;
   localparam logic [7:0] CICR_RST_FULL_SCALE_LOW = 8'h00;
   localparam logic [CICR_FSC_HIGH_W-1:0] CICR_RST_FULL_SCALE_HIGH = 2'h2;
   localparam logic CICR_RST_SLEEP = 1'b0;
   localparam logic CICR_RST_AUTO_RETRACK = 1'b1;
   localparam logic CICR_RST_ROLE = 1'b0;
   localparam logic CICR_RST_CTL_ENABLE = 1'b0;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [CICR_MODE_W-1:0] {
      CICR_MODE_BASEBAND = 2'h0,
      CICR_MODE_RETURN_TO_ZERO = 2'h1,
      CICR_MODE_MIX = 2'h2,
      CICR_MODE_RESERVED = 2'h3
   } cicr_mode_t;

   // Level status from the controllers and phase comparators.
   typedef struct packed {
      logic [CICR_NUM_CTL-1:0] locked;
      logic [CICR_NUM_CTL-1:0] lost;
      logic clock_early_vs_phase0;
      logic clock_late_vs_phase0;
      logic sync_in_vs_phase90;
      logic sync_in_vs_phase0;
   } cicr_status_t;

   // Configuration driven into the sync and receiver controllers.
   typedef struct packed {
      logic sync_controller_enable;
      logic sync_role_select;
      logic sync_auto_retrack;
      logic sync_flag_clear;
      logic receiver_controller_enable;
      logic receiver_auto_retrack;
      logic receiver_flag_clear;
   } cicr_ctl_cfg_t;

   localparam int CICR_STATUS_W = $bits(cicr_status_t);

endpackage

// ===== design/cicr_regs.sv
// Control and status register bank for the converter's controllers, current setting and output mode.
//
// Operation
// - Six write-only enables; writing 0 disables and clears the matching status bit.
// - Lock status reads 1 while locked; lost status reads 1 once unlocked.
// - Three controllers, each lock and lost enable matching its status bit position.
// - Ten-bit full-scale code: low byte at one register, two high bits above.
// - Sleep bit 7 of the high full-scale register disables the converter output.
// - Two-bit output mode: baseband, return-to-zero or mix; resets to baseband.
// - Status bit 2 is 1 when data clock leads the early phase-0 copy.
// - Status bit 0 is 1 when data clock leads the late phase-0 copy.
// - Sync input timing: bit 5 versus phase 90, bit 4 versus phase 0.
// - Sync auto-retrack, reset 1: master losing lock interrupts and restarts search.
// - Bit 5 selects sync role: 0 slave, 1 master; resets to slave.
// - Bit 4 enables the sync controller; resets disabled.
// - Receiver auto-retrack, reset 1: losing lock interrupts and restarts search.
// - Bit 0 enables the data receiver controller; resets disabled.
`timescale 1ns/10ps
`default_nettype none

module cicr_regs
   import cicr_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire cicr_status_t status_i,
   output cicr_ctl_cfg_t ctl_cfg_o,
   output logic sync_restart_o,
   output logic receiver_restart_o,
   output logic [CICR_IRQ_W-1:0] irq_flags_o,
   output logic [CICR_FSC_W-1:0] full_scale_code_o,
   output logic sleep_o,
   output cicr_mode_t output_switch_mode_o
);

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   if (ADDR_W < 8)
   begin : g_addr_check
      $error("cicr_regs: ADDR_W must be at least 8");
   end

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   // Status comes from controllers and comparators on other clocks, so every
   // bit passes two flip-flops before any logic looks at it.
   cicr_status_t status_meta;
   cicr_status_t status_s;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         status_meta <= '0;
         status_s <= '0;
      end
      else
      begin
         status_meta <= status_i;
         status_s <= status_meta;
      end
   end

   // ==========================================================================
   // Address decode
   // ==========================================================================
   wire logic [7:0] addr_lo = reg_addr_i[7:0];
   wire logic addr_hi_zero = (reg_addr_i == ADDR_W'(addr_lo));
   wire logic wr_enables = reg_wr_i && addr_hi_zero && (addr_lo == CICR_ADDR_IRQ_ENABLES);
   wire logic wr_fsc_low = reg_wr_i && addr_hi_zero && (addr_lo == CICR_ADDR_FULL_SCALE_LOW);
   wire logic wr_fsc_high = reg_wr_i && addr_hi_zero && (addr_lo == CICR_ADDR_FULL_SCALE_HIGH_SLEEP);
   wire logic wr_mode = reg_wr_i && addr_hi_zero && (addr_lo == CICR_ADDR_OUTPUT_SWITCH_MODE);
   wire logic wr_rcfg = reg_wr_i && addr_hi_zero && (addr_lo == CICR_ADDR_RECEIVER_CONFIG);

   // ==========================================================================
   // Writable registers
   // ==========================================================================
   logic [CICR_IRQ_W-1:0] irq_enable;
   logic [7:0] fsc_low;
   logic [CICR_FSC_HIGH_W-1:0] fsc_high;
   logic sleep;
   cicr_mode_t mode;
   cicr_ctl_cfg_t cfg;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_enable <= CICR_RST_IRQ_ENABLES;
         fsc_low <= CICR_RST_FULL_SCALE_LOW;
         fsc_high <= CICR_RST_FULL_SCALE_HIGH;
         sleep <= CICR_RST_SLEEP;
         mode <= CICR_MODE_BASEBAND;
      end
      else
      begin
         if (wr_enables)
            irq_enable <= reg_wdata_i[CICR_IRQ_W-1:0];
         if (wr_fsc_low)
            fsc_low <= reg_wdata_i;
         if (wr_fsc_high)
         begin
            fsc_high <= reg_wdata_i[CICR_FSC_HIGH_W-1:0];
            sleep <= reg_wdata_i[CICR_SLEEP_BIT];
         end
         if (wr_mode)
            mode <= cicr_mode_t'(reg_wdata_i[CICR_MODE_W-1:0]);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cfg.sync_flag_clear <= 1'b0;
         cfg.sync_auto_retrack <= CICR_RST_AUTO_RETRACK;
         cfg.sync_role_select <= CICR_RST_ROLE;
         cfg.sync_controller_enable <= CICR_RST_CTL_ENABLE;
         cfg.receiver_flag_clear <= 1'b0;
         cfg.receiver_auto_retrack <= CICR_RST_AUTO_RETRACK;
         cfg.receiver_controller_enable <= CICR_RST_CTL_ENABLE;
      end
      else if (wr_rcfg)
      begin
         cfg.sync_flag_clear <= reg_wdata_i[CICR_SYNC_FLAG_CLEAR_BIT];
         cfg.sync_auto_retrack <= reg_wdata_i[CICR_SYNC_AUTO_RETRACK_BIT];
         cfg.sync_role_select <= reg_wdata_i[CICR_SYNC_ROLE_BIT];
         cfg.sync_controller_enable <= reg_wdata_i[CICR_SYNC_ENABLE_BIT];
         cfg.receiver_flag_clear <= reg_wdata_i[CICR_RCV_FLAG_CLEAR_BIT];
         cfg.receiver_auto_retrack <= reg_wdata_i[CICR_RCV_AUTO_RETRACK_BIT];
         cfg.receiver_controller_enable <= reg_wdata_i[CICR_RCV_ENABLE_BIT];
      end
   end

   // ==========================================================================
   // Interrupt status flags
   // ==========================================================================
   // A controller with its enables at 0 or its flag clear set holds its flags at zero; the clear wins
   // over a simultaneous event so that software sees a clean re-arm.
   logic [CICR_IRQ_W-1:0] irq_flags;
   logic [CICR_IRQ_W-1:0] next_irq_flags;
   logic [CICR_NUM_CTL-1:0] ctl_flag_clear;
   logic [CICR_NUM_CTL-1:0] lost_event;

   assign ctl_flag_clear[CICR_CTL_RECEIVER] = cfg.receiver_flag_clear;
   assign ctl_flag_clear[CICR_CTL_PHASE_LOOP] = 1'b0;
   assign ctl_flag_clear[CICR_CTL_SYNC] = cfg.sync_flag_clear;

   for (genvar i = 0; i < CICR_NUM_CTL; i++)
   begin : g_ctl
      wire logic lock_en = irq_enable[2*i] && !ctl_flag_clear[i];
      wire logic lost_en = irq_enable[2*i+1] && !ctl_flag_clear[i];
      // Lock flag follows the lock level; lost flag is sticky once unlocked.
      assign next_irq_flags[2*i] = lock_en && status_s.locked[i];
      assign next_irq_flags[2*i+1] = lost_en && (status_s.lost[i] || irq_flags[2*i+1]);
      assign lost_event[i] = lost_en && status_s.lost[i] && !irq_flags[2*i+1];
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         irq_flags <= '0;
      else
         irq_flags <= next_irq_flags;
   end

   // ==========================================================================
   // Automatic retrack requests
   // ==========================================================================
   // Sync retrack only applies to the master; a slave follows its master.
   wire logic next_sync_restart = lost_event[CICR_CTL_SYNC] && cfg.sync_auto_retrack
      && cfg.sync_role_select && cfg.sync_controller_enable;
   wire logic next_receiver_restart = lost_event[CICR_CTL_RECEIVER] && cfg.receiver_auto_retrack
      && cfg.receiver_controller_enable;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sync_restart_o <= 1'b0;
         receiver_restart_o <= 1'b0;
      end
      else
      begin
         sync_restart_o <= next_sync_restart;
         receiver_restart_o <= next_receiver_restart;
      end
   end

   // ==========================================================================
   // Read path
   // ==========================================================================
   // Write-only bits and unmapped addresses read as zero.
   logic [7:0] rd_value;

   always_comb
   begin
      rd_value = 8'h00;
      if (addr_hi_zero)
      begin
         case (addr_lo)
            CICR_ADDR_IRQ_STATUS:
               rd_value[CICR_IRQ_W-1:0] = irq_flags;
            CICR_ADDR_FULL_SCALE_LOW:
               rd_value = fsc_low;
            CICR_ADDR_FULL_SCALE_HIGH_SLEEP:
            begin
               rd_value[CICR_FSC_HIGH_W-1:0] = fsc_high;
               rd_value[CICR_SLEEP_BIT] = sleep;
            end
            CICR_ADDR_OUTPUT_SWITCH_MODE:
               rd_value[CICR_MODE_W-1:0] = mode;
            CICR_ADDR_CLOCK_PHASE_STATUS:
            begin
               rd_value[CICR_CLOCK_EARLY_BIT] = status_s.clock_early_vs_phase0;
               rd_value[CICR_CLOCK_LATE_BIT] = status_s.clock_late_vs_phase0;
            end
            CICR_ADDR_SYNC_INPUT_PHASE_STATUS:
            begin
               rd_value[CICR_SYNC_PH90_BIT] = status_s.sync_in_vs_phase90;
               rd_value[CICR_SYNC_PH0_BIT] = status_s.sync_in_vs_phase0;
            end
            CICR_ADDR_RECEIVER_CONFIG:
            begin
               rd_value[CICR_SYNC_AUTO_RETRACK_BIT] = cfg.sync_auto_retrack;
               rd_value[CICR_SYNC_ROLE_BIT] = cfg.sync_role_select;
               rd_value[CICR_SYNC_ENABLE_BIT] = cfg.sync_controller_enable;
               rd_value[CICR_RCV_AUTO_RETRACK_BIT] = cfg.receiver_auto_retrack;
               rd_value[CICR_RCV_ENABLE_BIT] = cfg.receiver_controller_enable;
            end
            default:
               rd_value = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
            reg_rdata_o <= rd_value;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign ctl_cfg_o = cfg;
   assign irq_flags_o = irq_flags;
   assign full_scale_code_o = {fsc_high, fsc_low};
   assign sleep_o = sleep;
   assign output_switch_mode_o = mode;

endmodule

`default_nettype wire

// ===== bench/cicr_regs_asserts.sv
// Assertion checker for the converter control register bank.
`timescale 1ns/10ps
`default_nettype none
module cicr_regs_asserts
   import cicr_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire cicr_status_t status_i,
   input wire cicr_ctl_cfg_t ctl_cfg_o,
   input wire logic sync_restart_o,
   input wire logic receiver_restart_o,
   input wire logic [CICR_IRQ_W-1:0] irq_flags_o,
   input wire logic [CICR_FSC_W-1:0] full_scale_code_o,
   input wire logic sleep_o,
   input wire cicr_mode_t output_switch_mode_o
);
   // =========
   // Properties
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic wr_cfg = reg_wr_i && reg_addr_i == 8'h10;
   AST_STATUS_READ:
      assert property (reg_rd_i && reg_addr_i == 8'h04 |=> reg_rvalid_o && reg_rdata_o == {2'h0, $past(irq_flags_o)})
      else $error("status read mismatch");
   AST_MODE_READ:
      assert property (reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o == {6'h00, $past(output_switch_mode_o)})
      else $error("mode read mismatch");
   AST_FSC_LOW:
      assert property (reg_wr_i && reg_addr_i == 8'h06 |=> full_scale_code_o[7:0] == $past(reg_wdata_i))
      else $error("full scale low not stored");
   AST_FSC_HIGH:
      assert property (reg_wr_i && reg_addr_i == 8'h07 |=> full_scale_code_o[9:8] == $past(reg_wdata_i[1:0])
         && sleep_o == $past(reg_wdata_i[7]))
      else $error("full scale high or sleep not stored");
   AST_ENABLE_CLEAR:
      assert property (reg_wr_i && reg_addr_i == 8'h03 |-> ##2 (irq_flags_o & ~$past(reg_wdata_i[5:0], 2)) == 6'h00)
      else $error("disabled flag not cleared");
   AST_CFG_WRITE:
      assert property (wr_cfg |=> ctl_cfg_o.sync_role_select == $past(reg_wdata_i[5])
         && ctl_cfg_o.sync_controller_enable == $past(reg_wdata_i[4])
         && ctl_cfg_o.receiver_controller_enable == $past(reg_wdata_i[0]))
      else $error("controller config not stored");
   AST_SYNC_CLEAR:
      assert property (ctl_cfg_o.sync_flag_clear |=> irq_flags_o[5:4] == 2'h0)
      else $error("sync flags not held clear");
   AST_RCV_CLEAR:
      assert property (ctl_cfg_o.receiver_flag_clear |=> irq_flags_o[1:0] == 2'h0)
      else $error("receiver flags not held clear");
   AST_RCV_RESTART:
      assert property (receiver_restart_o |-> irq_flags_o[1] && ctl_cfg_o.receiver_auto_retrack ##1 !receiver_restart_o)
      else $error("receiver restart without cause");
   AST_SYNC_RESTART:
      assert property (sync_restart_o |-> irq_flags_o[5] && ctl_cfg_o.sync_role_select && ctl_cfg_o.sync_auto_retrack)
      else $error("sync restart without cause");
   cover property (receiver_restart_o);
   cover property (sync_restart_o);
   cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
endmodule
`default_nettype wire

// ===== bench/cicr_ctl_model.sv
// Behavioural model of the lock controllers and phase comparators feeding the register bank.
`timescale 1ns/10ps
`default_nettype none
module cicr_ctl_model
   import cicr_pkg::*;
(
   input wire cicr_ctl_cfg_t cfg_i,
   input wire logic [2:0] drop_i,
   input wire logic [3:0] phase_i,
   output cicr_status_t status_o
);
   // An enabled controller is locked unless told to fall out of lock.
   // The phase loop has no enable here, so it is taken as always running.
   wire logic [2:0] running = {cfg_i.sync_controller_enable, 1'b1, cfg_i.receiver_controller_enable};
   assign status_o.locked = running & ~drop_i;
   assign status_o.lost = running & drop_i;
   assign status_o.clock_early_vs_phase0 = phase_i[3];
   assign status_o.clock_late_vs_phase0 = phase_i[2];
   assign status_o.sync_in_vs_phase90 = phase_i[1];
   assign status_o.sync_in_vs_phase0 = phase_i[0];
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking testbench for the converter control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import cicr_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [2:0] drop = 3'h0;
   logic [3:0] phase = 4'h0;
   logic [7:0] rdata;
   logic rvalid, s_rst, r_rst, sleep;
   logic [5:0] flags;
   logic [9:0] full_scale_code;
   cicr_status_t status;
   cicr_ctl_cfg_t cfg;
   cicr_mode_t mode;
   int miscompares = 0;
   int n_checks = 0;
   always #50 sys_clk = ~sys_clk;
   cicr_regs #(.ADDR_W(8)) i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .status_i(status),
      .ctl_cfg_o(cfg), .sync_restart_o(s_rst), .receiver_restart_o(r_rst), .irq_flags_o(flags),
      .full_scale_code_o(full_scale_code), .sleep_o(sleep), .output_switch_mode_o(mode));
   cicr_ctl_model i_model (.cfg_i(cfg), .drop_i(drop), .phase_i(phase), .status_o(status));
   // =========
   // Bus tasks
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      n_checks++;
      if (got !== exp) miscompares++;
      if (got !== exp) $display("unexpected %s: expected %h, seen %h", what, exp, got);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read valid", 10'h001, {9'h000, rvalid});
      chk($sformatf("register %h", a), {2'h0, exp}, {2'h0, rdata});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Counts restart pulses over a fixed window after the lock levels change.
   task automatic lock_step(input logic [2:0] d, input int er, input int es);
      int hr, hs;
      hr = 0;
      hs = 0;
      @(posedge sys_clk);
      drop <= d;
      repeat (8)
      begin
         @(posedge sys_clk);
         #1;
         hr += (r_rst === 1'b1);
         hs += (s_rst === 1'b1);
      end
      chk("receiver restarts", er[9:0], hr[9:0]);
      chk("sync restarts", es[9:0], hs[9:0]);
   endtask
   // =========
   // Scenarios
   task automatic t_reset;
      rd(8'h06, 8'h00);
      rd(8'h07, 8'h02);
      rd(8'h08, 8'h00);
      rd(8'h10, 8'h42);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h05, 8'h00);
      chk("full scale code", 10'h200, full_scale_code);
   endtask
   task automatic t_fsc;
      wr(8'h06, 8'hff);
      wr(8'h07, 8'h83);
      rd(8'h07, 8'h83);
      chk("full scale code", 10'h3ff, full_scale_code);
      chk("sleep", 10'h001, {9'h000, sleep});
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h00);
      rd(8'h06, 8'h00);
      chk("full scale code", 10'h000, full_scale_code);
      chk("sleep", 10'h000, {9'h000, sleep});
   endtask
   task automatic t_mode;
      for (int m = 3; m >= 0; m--)
      begin
         wr(8'h08, m[7:0]);
         rd(8'h08, m[7:0]);
         chk("switch mode", m[9:0], {8'h00, mode});
      end
   endtask
   task automatic t_cfg;
      wr(8'h10, 8'hb5);
      rd(8'h10, 8'h31);
      chk("flag clears", 10'h003, {8'h00, cfg.sync_flag_clear, cfg.receiver_flag_clear});
      wr(8'h10, 8'h73);
      rd(8'h10, 8'h73);
      chk("controller config", 10'h076, {3'h0, cfg});
   endtask
   task automatic t_phase;
      logic [7:0] ec[4] = '{8'h04, 8'h01, 8'h00, 8'h00};
      logic [7:0] ed[4] = '{8'h00, 8'h00, 8'h20, 8'h10};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         phase <= 4'(4'h8 >> i);
         idle(4);
         rd(8'h0c, ec[i]);
         rd(8'h0d, ed[i]);
      end
      @(posedge sys_clk);
      phase <= 4'h0;
   endtask
   task automatic t_irq;
      wr(8'h03, 8'h3f);
      idle(4);
      rd(8'h04, 8'h15);
      chk("irq flags", 10'h015, {4'h0, flags});
      lock_step(3'h1, 1, 0);
      rd(8'h04, 8'h16);
      lock_step(3'h0, 0, 0);
      rd(8'h04, 8'h17);
      wr(8'h03, 8'h3c);
      rd(8'h04, 8'h14);
      wr(8'h03, 8'h3f);
      idle(4);
      rd(8'h04, 8'h15);
      lock_step(3'h2, 0, 0);
      rd(8'h04, 8'h19);
      lock_step(3'h4, 0, 1);
      rd(8'h04, 8'h2d);
      wr(8'h10, 8'hf3);
      rd(8'h04, 8'h0d);
      // Relock while the clear is held, so no lost level is still in flight when it is released.
      lock_step(3'h0, 0, 0);
      wr(8'h10, 8'h73);
      rd(8'h04, 8'h1d);
      wr(8'h10, 8'h77);
      rd(8'h04, 8'h1c);
      wr(8'h10, 8'h73);
      idle(4);
      rd(8'h04, 8'h1d);
      // Slave sync and receiver without retrack must flag the loss but never restart.
      wr(8'h10, 8'h51);
      lock_step(3'h5, 0, 0);
      rd(8'h04, 8'h2e);
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset;
      t_fsc;
      t_mode;
      t_cfg;
      t_phase;
      t_irq;
      results;
   end
   initial
   begin
      #200000;
      miscompares++;
      results;
   end
endmodule
bind cicr_regs cicr_regs_asserts #(.ADDR_W(ADDR_W)) i_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .status_i(status_i), .ctl_cfg_o(ctl_cfg_o),
   .sync_restart_o(sync_restart_o), .receiver_restart_o(receiver_restart_o), .irq_flags_o(irq_flags_o),
   .full_scale_code_o(full_scale_code_o), .sleep_o(sleep_o), .output_switch_mode_o(output_switch_mode_o));
`default_nettype wire
